// >>> hdl/uaec_pkg.sv
// uaec_pkg: register map, field layout, reset values and enums of the usb
// address and endpoint configuration block.
// assumes an 8-bit register port clocked at 40 MHz on a single clock.
// How it works
// - address register bit 7 turns address filtering on or off; resets to one.
// - seven-bit device address is zero after power-up and after usb bus reset.
// - endpoint-select bits 7-4 read zero; firmware never writes ones there.
// - endpoint-select index picks which endpoint the indexed registers reach.
// - endpoint enable bit activates the selected endpoint; clearing deactivates it.
// - endpoint zero is enabled after every hardware and usb bus reset.
// - toggle bit sets on accepted DATA0, clears on accepted DATA1.
// - for non-control endpoints direction bit one is IN, zero is OUT.
// - direction bit has no effect on a control endpoint.
// - type field decodes 00 control, 01 isochronous, 10 bulk, 11 interrupt.
// - endpoint zero is always treated as control, whatever its type field holds.
// - control register resets to 80h for endpoint zero, 00h for others.
// - control register bits 6-4 read zero; firmware must not set them.
package uaec_pkg;
    localparam int         UAEC_NUM_EP        = 16;
    localparam logic [7:0] UAEC_ADDR_DEV      = 8'hC6;
    localparam logic [7:0] UAEC_ADDR_EPSEL    = 8'hC7;
    localparam logic [7:0] UAEC_ADDR_EPSTAT   = 8'hCE;
    localparam logic [7:0] UAEC_ADDR_EPCTRL   = 8'hD4;
    localparam logic [7:0] UAEC_RST_DEV       = 8'h80;
    localparam logic [7:0] UAEC_RST_EPCTRL0   = 8'h80;
    localparam logic [7:0] UAEC_RST_EPCTRL    = 8'h00;
    localparam logic [7:0] UAEC_RST_EPSTAT    = 8'h00;
    localparam logic [3:0] UAEC_RST_EPSEL     = 4'h0;
    localparam int         UAEC_FILT_BIT      = 7;
    localparam int         UAEC_EN_BIT        = 7;
    localparam int         UAEC_TGL_BIT       = 3;
    localparam int         UAEC_DIR_BIT       = 2;
    localparam logic [7:0] UAEC_DEV_WMASK     = 8'hFF;
    localparam logic [7:0] UAEC_CTRL_WMASK    = 8'h87;
    localparam logic [7:0] UAEC_CTRL_RMASK    = 8'h8F;
    typedef enum logic [1:0] {
        UAEC_TYPE_CTRL = 2'b00,
        UAEC_TYPE_ISO  = 2'b01,
        UAEC_TYPE_BULK = 2'b10,
        UAEC_TYPE_INTR = 2'b11
    } uaec_type_e;
endpackage : uaec_pkg

// >>> hdl/uaec_ep_ctrl.sv
// uaec_ep_ctrl: control register of one endpoint with hardware toggle.
// assumes synchronous usb bus reset pulse and one-cycle data acceptance events.
`timescale 1ns/1ps
module uaec_ep_ctrl
    import uaec_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       bus_reset,
    // firmware write
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // accepted data packet events
    input  wire logic       data0_ok,
    input  wire logic       data1_ok,
    // register content
    output logic      [7:0] ctrl_q
);
    logic [7:0] ctrl_d;
    logic       tgl_d;

    // firmware cannot touch the toggle, hardware owns it
    assign tgl_d = data0_ok ? 1'b1 : (data1_ok ? 1'b0 : ctrl_q[UAEC_TGL_BIT]);
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en) begin
            ctrl_d = (wr_data & UAEC_CTRL_WMASK) | (ctrl_q & ~UAEC_CTRL_WMASK);
        end
        ctrl_d[UAEC_TGL_BIT] = tgl_d;
        ctrl_d = ctrl_d & UAEC_CTRL_RMASK;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= RST_VAL;
        end else if (bus_reset) begin
            ctrl_q <= RST_VAL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    tgl_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (data0_ok && !bus_reset) |=> ctrl_q[UAEC_TGL_BIT]) else $error("toggle not set on data0");
    tgl_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (data1_ok && !data0_ok && !bus_reset) |=> !ctrl_q[UAEC_TGL_BIT]) else $error("toggle not cleared");
    ctrl_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[6:4] == 3'b000) else $error("reserved control bits set");
endmodule : uaec_ep_ctrl

// >>> hdl/uaec_top.sv
// uaec_top: device address, endpoint select and indexed endpoint control
// registers of a full-speed usb device function, plus token address filter.
// assumes the serial engine gives one-cycle token and data-accept pulses
// synchronous to clk, and firmware uses a one-cycle strobe register port.
`timescale 1ns/1ps
module uaec_top
    import uaec_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        usb_bus_reset,
    // firmware register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // token stream from the serial engine
    input  wire logic        tok_valid,
    input  wire logic [6:0]  tok_addr,
    input  wire logic [3:0]  tok_ep,
    // accepted data packet on the token's endpoint
    input  wire logic        data_ok,
    input  wire logic        data_pid1,
    // endpoint status register content, owned by the transfer logic
    input  wire logic [7:0]  ep_status,
    // results to the transfer logic
    output logic             tok_accept,
    output logic [3:0]       tok_ep_q,
    output logic             tok_ep_active,
    output logic [1:0]       tok_ep_type,
    output logic             tok_ep_in,
    output logic [3:0]       endpoint_index_q,
    output logic [6:0]       device_addr_q
);
    // reset release through two flops
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // address decode
    wire sel_dev   = (reg_addr == UAEC_ADDR_DEV);
    wire sel_epsel = (reg_addr == UAEC_ADDR_EPSEL);
    wire sel_stat  = (reg_addr == UAEC_ADDR_EPSTAT);
    wire sel_ctrl  = (reg_addr == UAEC_ADDR_EPCTRL);

    // device address register
    logic       addr_filter_on_q;
    logic [6:0] device_addr_field_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            addr_filter_on_q    <= UAEC_RST_DEV[UAEC_FILT_BIT];
            device_addr_field_q <= UAEC_RST_DEV[6:0];
        end else if (usb_bus_reset) begin
            device_addr_field_q <= UAEC_RST_DEV[6:0];
        end else if (reg_wr && sel_dev) begin
            addr_filter_on_q    <= reg_wdata[UAEC_FILT_BIT];
            device_addr_field_q <= reg_wdata[6:0];
        end
    end

    // endpoint select; upper bits never stored
    logic [3:0] endpoint_index_int_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            endpoint_index_int_q <= UAEC_RST_EPSEL;
        end else if (reg_wr && sel_epsel) begin
            endpoint_index_int_q <= reg_wdata[3:0];
        end
    end

    // per-endpoint control registers
    logic [7:0] ctrl_arr [UAEC_NUM_EP];
    wire        data0_ev = data_ok && !data_pid1;
    wire        data1_ev = data_ok && data_pid1;
    genvar g;
    generate
        for (g = 0; g < UAEC_NUM_EP; g++) begin : g_ep
            wire        wr_this = reg_wr && sel_ctrl && (endpoint_index_int_q == 4'(g));
            wire        ev_this = (tok_ep_q == 4'(g));
            uaec_ep_ctrl #(
                .RST_VAL ((g == 0) ? UAEC_RST_EPCTRL0 : UAEC_RST_EPCTRL)
            ) u_ep (
                .clk      (clk),
                .rst_n    (rst_n_q),
                .bus_reset(usb_bus_reset),
                .wr_en    (wr_this),
                .wr_data  (reg_wdata),
                .data0_ok (data0_ev && ev_this),
                .data1_ok (data1_ev && ev_this),
                .ctrl_q   (ctrl_arr[g])
            );
        end
    endgenerate

    // read mux, data in the cycle after the strobe
    wire [7:0] sel_ctrl_val = ctrl_arr[endpoint_index_int_q];
    wire [7:0] rd_mux = sel_dev   ? {addr_filter_on_q, device_addr_field_q} :
                        sel_epsel ? {4'h0, endpoint_index_int_q} :
                        sel_stat  ? ep_status :
                        sel_ctrl  ? sel_ctrl_val : 8'h00;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // token filter and endpoint decode
    wire [7:0] tok_ctrl    = ctrl_arr[tok_ep];
    wire       tok_is_ctrl = (tok_ep == 4'h0) || (uaec_type_e'(tok_ctrl[1:0]) == UAEC_TYPE_CTRL);
    wire       addr_match  = !addr_filter_on_q || (tok_addr == device_addr_field_q);
    wire       accept_d    = tok_valid && addr_match;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tok_accept    <= 1'b0;
            tok_ep_q      <= 4'h0;
            tok_ep_active <= 1'b0;
            tok_ep_type   <= 2'b00;
            tok_ep_in     <= 1'b0;
        end else begin
            tok_accept <= accept_d;
            if (accept_d) begin
                tok_ep_q      <= tok_ep;
                tok_ep_active <= tok_ctrl[UAEC_EN_BIT];
                tok_ep_type   <= tok_is_ctrl ? UAEC_TYPE_CTRL : tok_ctrl[1:0];
                tok_ep_in     <= !tok_is_ctrl && tok_ctrl[UAEC_DIR_BIT];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            endpoint_index_q <= 4'h0;
            device_addr_q    <= 7'h00;
        end else begin
            endpoint_index_q <= endpoint_index_int_q;
            device_addr_q    <= device_addr_field_q;
        end
    end

    filt_reject_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        (tok_valid && addr_filter_on_q && tok_addr != device_addr_field_q) |=> !tok_accept)
        else $error("token with foreign address accepted");
    filt_off_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        (tok_valid && !addr_filter_on_q) |=> tok_accept) else $error("unfiltered token dropped");
    addr_busrst_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        usb_bus_reset |=> ##1 device_addr_q == 7'h00) else $error("address kept over bus reset");
    ep0_busrst_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        usb_bus_reset |=> ctrl_arr[0] == UAEC_RST_EPCTRL0) else $error("endpoint zero not reset enabled");
    epsel_rd_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        (reg_rd && sel_epsel) |=> reg_rdata[7:4] == 4'h0) else $error("select upper bits nonzero");
    ctrl_rd_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        (reg_rd && sel_ctrl && !reg_wr) |=> reg_rdata == $past(sel_ctrl_val)) else $error("indexed read wrong");
    ctrl_dir_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        (accept_d && tok_is_ctrl) |=> !tok_ep_in && tok_ep_type == 2'b00) else $error("control endpoint dir used");
    ep_enable_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        (accept_d) |=> tok_ep_active == $past(tok_ctrl[UAEC_EN_BIT])) else $error("enable not honoured");
    ep_dir_a: assert property (@(posedge clk) disable iff (!rst_n_q)
        (accept_d && !tok_is_ctrl) |=> tok_ep_in == $past(tok_ctrl[UAEC_DIR_BIT])) else $error("direction wrong");

    tok_acc_c: cover property (@(posedge clk) disable iff (!rst_n_q) accept_d && addr_filter_on_q);
    addr_wr_c: cover property (@(posedge clk) disable iff (!rst_n_q) reg_wr && sel_dev);
    busrst_c:  cover property (@(posedge clk) disable iff (!rst_n_q) usb_bus_reset);
    data1_c:   cover property (@(posedge clk) disable iff (!rst_n_q) data1_ev);
endmodule : uaec_top

// >>> tb/uaec_host_model.sv
// uaec_host_model: usb host side as seen through the serial engine, issuing
// token and data-accept pulses. assumes the bench calls its tasks on clk.
`timescale 1ns/1ps
module uaec_host_model (
    // clock
    input  wire logic       clk,
    // token and data events
    output logic            tok_valid,
    output logic      [6:0] tok_addr,
    output logic      [3:0] tok_ep,
    output logic            data_ok,
    output logic            data_pid1
);
    initial begin
        tok_valid = 1'b0;
        tok_addr  = 7'h7f;
        tok_ep    = 4'hf;
        data_ok   = 1'b0;
        data_pid1 = 1'b0;
    end
    // lines stop showing the last value once the pulse is over
    task automatic token(input logic [6:0] a, input logic [3:0] ep);
        @(posedge clk);
        tok_valid <= 1'b1;
        tok_addr  <= a;
        tok_ep    <= ep;
        @(posedge clk);
        tok_valid <= 1'b0;
        tok_addr  <= ~a;
        tok_ep    <= ~ep;
    endtask : token
    task automatic data(input logic pid1);
        @(posedge clk);
        data_ok   <= 1'b1;
        data_pid1 <= pid1;
        @(posedge clk);
        data_ok   <= 1'b0;
        data_pid1 <= ~pid1;
    endtask : data
endmodule : uaec_host_model

// >>> tb/uaec_top_tb.sv
// uaec_top_tb: self-checking bench of the address and endpoint config block.
// assumes a single 40 MHz clock and the one-cycle strobe register port.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module uaec_top_tb;
    import uaec_pkg::*;
    logic clk, reset_n, usb_bus_reset, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ep_status;
    logic tok_valid, data_ok, data_pid1, tok_accept, tok_ep_active, tok_ep_in;
    logic [6:0] tok_addr, device_addr_q;
    logic [3:0] tok_ep, tok_ep_q, endpoint_index_q;
    logic [1:0] tok_ep_type;
    int n_mismatch = 0, checks = 0, cyc = 0;
    uaec_top u_uaec_top (.clk(clk), .reset_n(reset_n), .usb_bus_reset(usb_bus_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid),
        .tok_addr(tok_addr), .tok_ep(tok_ep), .data_ok(data_ok), .data_pid1(data_pid1), .ep_status(ep_status),
        .tok_accept(tok_accept), .tok_ep_q(tok_ep_q), .tok_ep_active(tok_ep_active), .tok_ep_type(tok_ep_type),
        .tok_ep_in(tok_ep_in), .endpoint_index_q(endpoint_index_q), .device_addr_q(device_addr_q));
    uaec_host_model u_uaec_host_model (.clk(clk), .tok_valid(tok_valid), .tok_addr(tok_addr),
        .tok_ep(tok_ep), .data_ok(data_ok), .data_pid1(data_pid1));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // a hang must not outlive 5000 cycles, far beyond the hundred or so the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0; reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(nm, ex, reg_rdata)
    endtask : rd
    // token through the host; accept flag is valid in the cycle after it
    task automatic tok(input logic [6:0] a, input logic [3:0] ep, input logic ex);
        u_uaec_host_model.token(a, ep);
        #1 `CHK("tok_accept", ex, tok_accept)
    endtask : tok
    task automatic t_reset_values;
        rd("dev_addr", UAEC_ADDR_DEV, 8'h80);
        rd("ep_select", UAEC_ADDR_EPSEL, 8'h00);
        rd("ep0_ctrl", UAEC_ADDR_EPCTRL, 8'h80);
        wr(UAEC_ADDR_EPSEL, 8'h01);
        rd("ep1_ctrl", UAEC_ADDR_EPCTRL, 8'h00);
        rd("unmapped", 8'h55, 8'h00);
        rd("ep_status", UAEC_ADDR_EPSTAT, 8'h5a);
        $display("test reset_values done");
    endtask : t_reset_values
    task automatic t_filter;
        tok(7'h00, 4'h0, 1'b1);
        `CHK("ep0_active", 1'b1, tok_ep_active)
        `CHK("ep0_type", 2'b00, tok_ep_type)
        wr(UAEC_ADDR_DEV, 8'h85);
        tok(7'h00, 4'h0, 1'b0);
        tok(7'h05, 4'h0, 1'b1);
        `CHK("dev_addr_copy", 7'h05, device_addr_q)
        wr(UAEC_ADDR_DEV, 8'h05);
        tok(7'h09, 4'h0, 1'b1);
        wr(UAEC_ADDR_DEV, 8'h85);
        $display("test filter done");
    endtask : t_filter
    task automatic t_endpoint;
        logic [1:0] ty;
        wr(UAEC_ADDR_EPSEL, 8'h02);
        wr(UAEC_ADDR_EPCTRL, 8'h8e);
        rd("ep2_ctrl", UAEC_ADDR_EPCTRL, 8'h86);
        for (int i = 0; i < 4; i++) begin
            ty = i[1:0];
            wr(UAEC_ADDR_EPCTRL, {6'b100001, ty});
            tok(7'h05, 4'h2, 1'b1);
            `CHK("ep_type", ty, tok_ep_type)
            `CHK("ep_in", (ty != 2'b00), tok_ep_in)
        end
        wr(UAEC_ADDR_EPCTRL, 8'h82);
        tok(7'h05, 4'h2, 1'b1);
        `CHK("ep_out", 1'b0, tok_ep_in)
        `CHK("tok_ep", 4'h2, tok_ep_q)
        `CHK("ep_index", 4'h2, endpoint_index_q)
        u_uaec_host_model.data(1'b0);
        rd("tgl_set", UAEC_ADDR_EPCTRL, 8'h8a);
        u_uaec_host_model.data(1'b1);
        rd("tgl_clr", UAEC_ADDR_EPCTRL, 8'h82);
        wr(UAEC_ADDR_EPCTRL, 8'h02);
        tok(7'h05, 4'h2, 1'b1);
        `CHK("ep_off", 1'b0, tok_ep_active)
        wr(UAEC_ADDR_EPSEL, 8'h00);
        rd("ep0_kept", UAEC_ADDR_EPCTRL, 8'h80);
        $display("test endpoint done");
    endtask : t_endpoint
    task automatic t_bus_reset;
        wr(UAEC_ADDR_EPCTRL, 8'h00);
        @(posedge clk) usb_bus_reset <= 1'b1;
        @(posedge clk) usb_bus_reset <= 1'b0;
        rd("addr_cleared", UAEC_ADDR_DEV, 8'h80);
        `CHK("dev_addr_zero", 7'h00, device_addr_q)
        rd("ep0_back", UAEC_ADDR_EPCTRL, 8'h80);
        wr(UAEC_ADDR_EPSEL, 8'h02);
        rd("ep2_cleared", UAEC_ADDR_EPCTRL, 8'h00);
        $display("test bus_reset done");
    endtask : t_bus_reset
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        reset_n = 1'b0; usb_bus_reset = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 8'h00; ep_status = 8'h5a;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset_values();
        t_filter();
        t_endpoint();
        t_bus_reset();
        end_sim();
    end
endmodule : uaec_top_tb
